// ### rtl/stepper_ctrl.sv
// top: register port, exchange words, safety stops and three axis channels
`timescale 1ns/1ps
// Notes on behaviour
// [R1] three channels: step, direction, boost outputs
// [R2] step rate never above 60 kHz
// [R3] home and probe inputs readable
// [R4] board code readable at 80h
// [R5] exchange through two 32-bit words
// [R6] interrupt on pending exchange word
// [R7] flags set on write, clear on read
// [R8] watchdog expiry halts all axes
// [R9] supply fault halts axes, flags host
// [R10] power fail halts all axes at once
// [R11] two travel limits per axis enforced
// [R12] offset compensation only with coprocessor
// [R13] direction settles before first step
module stepper_ctrl
    import stepper_pkg::*;
#(
    parameter logic [15:0] WDOG_TIMEOUT = WDOG_CYC,  // shorten in simulation
    parameter bit          HAS_COPROC   = 1'b0       // variant with offset compensation
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  bus_addr,           // host register address
    input  wire logic [31:0] bus_wdata,          // host write data
    input  wire logic        bus_wr,             // host write strobe
    input  wire logic        bus_rd,             // host read strobe
    output logic      [31:0] bus_rdata,          // host read data, one cycle later
    output logic             irq,                // level interrupt to host
    input  wire logic [7:0]  cpu_addr,           // internal processor address
    input  wire logic [31:0] cpu_wdata,          // internal processor write data
    input  wire logic        cpu_wr,             // internal processor write strobe
    input  wire logic        cpu_rd,             // internal processor read strobe
    output logic      [31:0] cpu_rdata,          // internal processor read data
    output logic             cpu_irq,            // interrupt to internal processor
    input  wire logic [2:0]  home_switch_in,     // reference switches, pins
    input  wire logic [2:0]  probe_in,           // measuring sensors, pins
    input  wire logic        supply_fault_in,    // analog supply fault, pin
    input  wire logic        power_fail_stop,    // power fail, pin
    output logic             step_pulse_out_1,
    output logic             step_pulse_out_2,
    output logic             step_pulse_out_3,
    output logic             rotation_sense_out_1,
    output logic             rotation_sense_out_2,
    output logic             rotation_sense_out_3,
    output logic             current_boost_out_1,
    output logic             current_boost_out_2,
    output logic             current_boost_out_3
);
    // whole module state
    typedef struct packed {
        logic [31:0]         host_word;  // host to processor
        logic [31:0]         cpu_word;   // processor to host
        logic [ST_BITS-1:0]  status;     // sticky events
        logic [ST_BITS-1:0]  mask;       // host interrupt mask
        logic [2:0]          boost;      // boost levels
        logic                stop;       // latched safety stop
        logic [15:0]         wdog;       // watchdog down counter
        logic [AXES-1:0][15:0]        rate;   // step period per axis
        logic signed [AXES-1:0][31:0] lolim;  // low travel limit per axis
        logic signed [AXES-1:0][31:0] hilim;  // high travel limit per axis
        logic [31:0]         rdata;
        logic [31:0]         crdata;
        logic                irq;
        logic                cirq;
        logic [2:0]          step;
        logic [2:0]          dir;
        logic [2:0]          bst;
    } top_t;

    top_t r;       // registered state
    top_t next_r;  // next state

    logic [2:0]  home_s;   // synchronised home switches
    logic [2:0]  probe_s;  // synchronised probes
    logic        fault_s;  // synchronised supply fault
    logic        pfail_s;  // synchronised power fail
    logic [2:0]  start;    // move request per axis
    logic [2:0]  refused;  // limit refusals per axis
    logic        halt;     // all-axis stop
    axis_out_t   ax [AXES];

    // pin inputs through two flops
    sync2 u_sync_h0 (.clk_sys(clk_sys), .rst_b(rst_b), .d(home_switch_in[0]), .q(home_s[0]));
    sync2 u_sync_h1 (.clk_sys(clk_sys), .rst_b(rst_b), .d(home_switch_in[1]), .q(home_s[1]));
    sync2 u_sync_h2 (.clk_sys(clk_sys), .rst_b(rst_b), .d(home_switch_in[2]), .q(home_s[2]));
    sync2 u_sync_p0 (.clk_sys(clk_sys), .rst_b(rst_b), .d(probe_in[0]), .q(probe_s[0]));
    sync2 u_sync_p1 (.clk_sys(clk_sys), .rst_b(rst_b), .d(probe_in[1]), .q(probe_s[1]));
    sync2 u_sync_p2 (.clk_sys(clk_sys), .rst_b(rst_b), .d(probe_in[2]), .q(probe_s[2]));
    sync2 u_sync_sf (.clk_sys(clk_sys), .rst_b(rst_b), .d(supply_fault_in), .q(fault_s));
    sync2 u_sync_pf (.clk_sys(clk_sys), .rst_b(rst_b), .d(power_fail_stop), .q(pfail_s));

    // any safety source halts every axis
    assign halt = r.stop || pfail_s || fault_s || (r.wdog == 16'h0000);  // R8 R9 R10

    // three axis channels
    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            assign start[g] = cpu_wr && (cpu_addr == A_AX_BASE + 8'(g) * A_AX_STRIDE + 8'(AX_MOVE));
            axis_channel u_axis (  // R1
                .clk_sys (clk_sys),
                .rst_b   (rst_b),
                .start   (start[g]),
                .mv_dir  (cpu_wdata[31]),
                .mv_cnt  (cpu_wdata[15:0]),
                .period  (r.rate[g]),
                .lo_lim  (r.lolim[g]),
                .hi_lim  (r.hilim[g]),
                .halt    (halt),
                .ax      (ax[g]),
                .refused (refused[g])
            );
        end
    endgenerate

    // register access, flags, safety and outputs
    always_comb begin
        logic [ST_BITS-1:0] ev;   // events this cycle
        logic [ST_BITS-1:0] clr;  // write-one-clear from host, clear on exchange word read
        logic [7:0]         off;  // axis-relative offset
        int                 k;    // axis index
        ev     = '0;
        clr    = '0;
        off    = 8'h00;
        k      = 0;
        next_r = r;

        // watchdog counts down, processor retriggers
        if (r.wdog != 16'h0000) next_r.wdog = r.wdog - 16'h0001;  // R8

        // host side: write
        if (bus_wr) begin
            case (bus_addr)
                A_HOST_MBOX: begin
                    next_r.host_word = bus_wdata;  // R5
                    ev[ST_HOST_FULL] = 1'b1;       // R7
                end
                A_STATUS: clr = bus_wdata[ST_BITS-1:0];
                A_MASK:   next_r.mask = bus_wdata[ST_BITS-1:0];
                default: ;
            endcase
        end
        // host side: read
        next_r.rdata = 32'h0000_0000;
        if (bus_rd) begin
            case (bus_addr)
                A_HOST_MBOX: next_r.rdata = r.host_word;
                A_CPU_MBOX: begin
                    next_r.rdata = r.cpu_word;  // R5
                    clr[ST_CPU_FULL] = 1'b1;    // R7
                end
                A_STATUS:   next_r.rdata = 32'(r.status);
                A_MASK:     next_r.rdata = 32'(r.mask);
                A_INPUTS:   next_r.rdata = {24'h000000, fault_s, pfail_s, probe_s, home_s};  // R3
                A_BOARD_ID: next_r.rdata = 32'(BOARD_CODE);  // R4
                default:    next_r.rdata = 32'h0000_0000;
            endcase
        end

        // processor side: write
        if (cpu_wr) begin
            if (cpu_addr == A_CPU_MBOX) begin
                next_r.cpu_word = cpu_wdata;  // R5
                ev[ST_CPU_FULL] = 1'b1;       // R7
            end else if (cpu_addr == A_CTRL) begin
                if (cpu_wdata[CT_WDOG_KICK]) next_r.wdog = WDOG_TIMEOUT;
                next_r.boost = cpu_wdata[CT_BOOST +: 3];
                if (cpu_wdata[CT_CLR_STOP]) next_r.stop = 1'b0;
            end else if (cpu_addr >= A_AX_BASE && cpu_addr < A_BOARD_ID) begin
                off = cpu_addr - A_AX_BASE;
                k   = int'(off[7:4]);
                if (k < AXES) begin
                    case (off[3:0])
                        AX_RATE:  next_r.rate[k]  = cpu_wdata[15:0];
                        AX_LOLIM: next_r.lolim[k] = cpu_wdata;  // R11
                        AX_HILIM: next_r.hilim[k] = cpu_wdata;  // R11
                        default: ;
                    endcase
                end
            end
        end
        // processor side: read
        next_r.crdata = 32'h0000_0000;
        if (cpu_rd) begin
            if (cpu_addr == A_HOST_MBOX) begin
                next_r.crdata = r.host_word;
                clr[ST_HOST_FULL] = 1'b1;  // R7
            end else if (cpu_addr == A_STATUS) begin
                next_r.crdata = 32'(r.status);   // sticky bits, variant flag on top
                next_r.crdata[31] = HAS_COPROC;  // R12
            end else if (cpu_addr == A_INPUTS) begin
                next_r.crdata = {24'h000000, fault_s, pfail_s, probe_s, home_s};  // R3
            end else if (cpu_addr >= A_AX_BASE && cpu_addr < A_BOARD_ID) begin
                off = cpu_addr - A_AX_BASE;
                k   = int'(off[7:4]);
                if (k < AXES) next_r.crdata = ax[k].pos;
            end
        end

        // safety events
        ev[ST_WDOG]   = (r.wdog == 16'h0001);  // R8
        ev[ST_SUPPLY] = fault_s;               // R9
        ev[ST_PFAIL]  = pfail_s;               // R10
        ev[ST_LIMIT]  = |refused;              // R11
        if (ev[ST_WDOG] || fault_s || pfail_s) next_r.stop = 1'b1;

        // set wins over clear
        next_r.status = (r.status & ~clr) | ev;
        next_r.irq    = |(next_r.status & r.mask);  // R6
        next_r.cirq   = next_r.status[ST_HOST_FULL];  // R6

        // outputs from flops
        for (int i = 0; i < AXES; i++) begin
            next_r.step[i] = ax[i].step;  // R1
            next_r.dir[i]  = ax[i].dir;   // R13
            next_r.bst[i]  = r.boost[i] && ax[i].busy && !halt;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r       <= '0;
            r.wdog  <= WDOG_CYC;
            for (int i = 0; i < AXES; i++) begin
                r.rate[i]  <= STEP_MIN_P;
                r.lolim[i] <= 32'sh8000_0000;
                r.hilim[i] <= 32'sh7FFF_FFFF;
            end
        end else begin
            r <= next_r;
        end
    end

    assign bus_rdata            = r.rdata;
    assign cpu_rdata            = r.crdata;
    assign irq                  = r.irq;
    assign cpu_irq              = r.cirq;
    assign step_pulse_out_1     = r.step[0];
    assign step_pulse_out_2     = r.step[1];
    assign step_pulse_out_3     = r.step[2];
    assign rotation_sense_out_1 = r.dir[0];
    assign rotation_sense_out_2 = r.dir[1];
    assign rotation_sense_out_3 = r.dir[2];
    assign current_boost_out_1  = r.bst[0];
    assign current_boost_out_2  = r.bst[1];
    assign current_boost_out_3  = r.bst[2];

    // host write to its word raises the pending flag next cycle
    sequence s_host_write;
        bus_wr && bus_addr == A_HOST_MBOX;
    endsequence
    a_flag_set : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R7
        s_host_write |=> r.status[ST_HOST_FULL])
        else $error("exchange flag not set");

    // pending flag raises processor interrupt
    a_cpu_irq : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R6
        r.status[ST_HOST_FULL] |=> cpu_irq || !r.status[ST_HOST_FULL])
        else $error("processor interrupt missing");

    // power fail stops pulses within a few cycles
    a_pfail_halt : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R10
        pfail_s |-> ##[1:8] !step_pulse_out_1 && !step_pulse_out_2 && !step_pulse_out_3)
        else $error("axes not stopped on power fail");

    // board code answers in the next cycle
    a_board_id : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R4
        (bus_rd && bus_addr == A_BOARD_ID) |=> bus_rdata == 32'(BOARD_CODE))
        else $error("wrong board code");

    // supply fault sets its flag
    a_supply : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R9
        fault_s |=> r.status[ST_SUPPLY])
        else $error("supply fault not flagged");

    // watchdog expiry latches the stop
    a_wdog_stop : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R8
        (r.wdog == 16'h0001) |=> r.stop)
        else $error("watchdog did not stop axes");
endmodule : stepper_ctrl

// ### rtl/stepper_pkg.sv
// package: constants, types and register map of the three-axis step pulse controller
package stepper_pkg;

    localparam int          AXES          = 3;           // number of axis channels
    localparam int          CLK_HZ        = 10000000;    // system clock rate
    localparam int          STEP_MAX_HZ   = 60000;       // highest step pulse rate
    // least step period in cycles, rounded up
    localparam int          STEP_MIN_CYC  = (CLK_HZ + STEP_MAX_HZ - 1) / STEP_MAX_HZ;
    localparam logic [15:0] STEP_MIN_P    = 16'(STEP_MIN_CYC);
    localparam logic [15:0] PULSE_HI_CYC  = 16'h0005;    // step high time in cycles
    localparam logic [15:0] DIR_SETUP_CYC = 16'h0004;    // direction settle before step
    localparam logic [15:0] WDOG_CYC      = 16'hFFFF;    // watchdog timeout in cycles

    // register offsets (byte addresses)
    localparam logic [7:0] A_HOST_MBOX  = 8'h00;  // host to processor exchange word
    localparam logic [7:0] A_CPU_MBOX   = 8'h04;  // processor to host exchange word
    localparam logic [7:0] A_STATUS     = 8'h08;  // sticky event bits, write one clears
    localparam logic [7:0] A_MASK       = 8'h0C;  // interrupt mask
    localparam logic [7:0] A_CTRL       = 8'h10;  // control bits
    localparam logic [7:0] A_INPUTS     = 8'h14;  // live sensor levels and flags
    localparam logic [7:0] A_AX_BASE    = 8'h20;  // axis block base
    localparam logic [7:0] A_AX_STRIDE  = 8'h10;  // bytes per axis block
    localparam logic [7:0] A_BOARD_ID   = 8'h80;  // board type code
    localparam logic [7:0] BOARD_CODE   = 8'h5A;  // arbitrary neutral value

    // axis block word offsets
    localparam logic [3:0] AX_MOVE  = 4'h0;  // write: [31] dir, [15:0] step count
    localparam logic [3:0] AX_RATE  = 4'h4;  // step period in cycles
    localparam logic [3:0] AX_LOLIM = 4'h8;  // low travel limit
    localparam logic [3:0] AX_HILIM = 4'hC;  // high travel limit; read gives position

    // status bits
    localparam int ST_HOST_FULL = 0;  // host word written
    localparam int ST_CPU_FULL  = 1;  // processor word written
    localparam int ST_WDOG      = 2;  // watchdog expired
    localparam int ST_SUPPLY    = 3;  // analog supply fault
    localparam int ST_PFAIL     = 4;  // power fail stop
    localparam int ST_LIMIT     = 5;  // move refused by limit
    localparam int ST_BITS      = 6;

    // control bits
    localparam int CT_WDOG_KICK = 0;  // processor watchdog retrigger (pulse)
    localparam int CT_BOOST     = 1;  // boost field [3:1]
    localparam int CT_CLR_STOP  = 4;  // clear latched stop (pulse)

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic        step;
        logic        dir;
        logic        busy;
        logic signed [31:0] pos;
    } axis_out_t;

endpackage : stepper_pkg

// ### rtl/sync2.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
module sync2 (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic d,
    output logic      q
);
    logic meta;  // first stage, read only by q

    // two stages, reset low
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sync2

// ### rtl/axis_channel.sv
// one axis: direction setup, rate-limited step pulses, position and limits
`timescale 1ns/1ps
module axis_channel
    import stepper_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic               start,     // one-cycle move request
    input  wire logic               mv_dir,    // requested direction
    input  wire logic [15:0]        mv_cnt,    // steps to make
    input  wire logic [15:0]        period,    // step period in cycles
    input  wire logic signed [31:0] lo_lim,    // low travel limit
    input  wire logic signed [31:0] hi_lim,    // high travel limit
    input  wire logic               halt,      // stop all motion
    output axis_out_t               ax,        // step, dir, busy, position
    output logic                    refused    // one-cycle: move beyond limit
);
    typedef enum logic [1:0] {IDLE, SETUP, HIGH, LOW} ph_t;

    typedef struct packed {
        ph_t               ph;
        logic              step;
        logic              dir;
        logic [15:0]       left;
        logic [15:0]       cnt;
        logic [15:0]       per;
        logic signed [31:0] pos;
        logic              refused;
    } st_t;

    st_t s;       // registered state
    st_t next_s;  // next state
    logic signed [31:0] target;  // end position of request
    logic               step_d;  // step one cycle back, for the rate check
    logic [15:0]        gap;     // cycles since the last rising step, saturating

    // next state
    always_comb begin
        next_s         = s;
        next_s.refused = 1'b0;
        target = mv_dir ? s.pos - 32'(mv_cnt) : s.pos + 32'(mv_cnt);
        if (s.cnt != 16'h0000) next_s.cnt = s.cnt - 16'h0001;
        case (s.ph)
            IDLE: begin
                next_s.step = 1'b0;
                if (start && !halt && mv_cnt != 16'h0000) begin
                    if (target < lo_lim || target > hi_lim) begin
                        next_s.refused = 1'b1;  // R11
                    end else begin
                        next_s.dir  = mv_dir;   // R13
                        next_s.left = mv_cnt;
                        next_s.per  = (period < STEP_MIN_P) ? STEP_MIN_P : period;  // R2
                        next_s.cnt  = DIR_SETUP_CYC;
                        next_s.ph   = SETUP;
                    end
                end
            end
            SETUP: if (s.cnt == 16'h0000) begin
                next_s.step = 1'b1;
                next_s.cnt  = PULSE_HI_CYC - 16'h0001;
                next_s.ph   = HIGH;
            end
            HIGH: if (s.cnt == 16'h0000) begin
                next_s.step = 1'b0;
                next_s.pos  = s.dir ? s.pos - 32'sd1 : s.pos + 32'sd1;
                next_s.left = s.left - 16'h0001;
                next_s.cnt  = s.per - PULSE_HI_CYC - 16'h0001;  // R2
                next_s.ph   = LOW;
            end
            LOW: if (s.cnt == 16'h0000) begin
                if (s.left == 16'h0000) begin
                    next_s.ph = IDLE;
                end else begin
                    next_s.step = 1'b1;
                    next_s.cnt  = PULSE_HI_CYC - 16'h0001;
                    next_s.ph   = HIGH;
                end
            end
            default: next_s.ph = IDLE;
        endcase
        // halt: no new pulse; a high phase finishes and the low phase runs out
        // its period, so a restart after the halt cannot beat the rate limit
        if (halt && s.ph == SETUP) begin
            next_s.ph   = IDLE;
            next_s.step = 1'b0;
        end else if (halt && s.ph == LOW) begin  // R10
            next_s.step = 1'b0;
            next_s.left = 16'h0000;
            next_s.ph   = (s.cnt == 16'h0000) ? IDLE : LOW;  // R2
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ax      = '{step: s.step, dir: s.dir, busy: (s.ph != IDLE), pos: s.pos};
    assign refused = s.refused;

    // direction never changes while a move runs
    a_dir_stable : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R13
        (s.ph != IDLE && $past(s.ph) != IDLE) |-> $stable(s.dir))
        else $error("direction changed during move");

    // spacing counter behind the rate check
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            step_d <= 1'b0;
            gap    <= 16'hFFFF;
        end else begin
            step_d <= s.step;
            if (s.step && !step_d) begin
                gap <= 16'h0001;
            end else if (gap != 16'hFFFF) begin
                gap <= gap + 16'h0001;
            end
        end
    end

    // two rising step edges are at least the minimum period apart
    a_step_rate : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R2
        (s.step && !step_d) |-> gap >= STEP_MIN_P)
        else $error("step rate above limit");

    // refused request does not start motion
    a_limit_hold : assert property (@(posedge clk_sys) disable iff (!rst_b)  // R11
        s.refused |-> s.ph == IDLE)
        else $error("motion started beyond limit");
endmodule : axis_channel

// ### tb/stepper_drive_model.sv
// behavioural power units and axis sensors at the step outputs
`timescale 1ns/1ps
module stepper_drive_model (
    input  wire logic        clk_sys,
    input  wire logic [2:0]  step,           // step pulse per channel
    input  wire logic [2:0]  dir,            // direction per channel
    input  wire logic [2:0]  home_cmd,       // bench-chosen switch levels
    input  wire logic [2:0]  probe_cmd,      // bench-chosen sensor levels
    output logic      [2:0]  home_switch_in,
    output logic      [2:0]  probe_in,
    output logic [2:0][15:0] steps,          // pulses counted per channel
    output int               min_gap,        // closest pulse spacing, cycles
    output logic             dir_moved       // direction changed at a step edge
);
    int         cyc;      // free cycle count
    int         last [3]; // cycle of the last rising edge
    logic [2:0] step_q;   // step one cycle back
    logic [2:0] dir_q;    // direction one cycle back
    assign home_switch_in = home_cmd;
    assign probe_in       = probe_cmd;
    initial begin
        cyc       = 0;
        steps     = '0;
        min_gap   = 1000000;
        dir_moved = 1'b0;
        foreach (last[i]) last[i] = -1000000;
    end
    // count pulses, spacing and direction setup per channel
    always @(posedge clk_sys) begin
        cyc    <= cyc + 1;
        step_q <= step;
        dir_q  <= dir;
        for (int i = 0; i < 3; i++) begin
            if (step[i] === 1'b1 && step_q[i] === 1'b0) begin
                steps[i] <= steps[i] + 16'h0001;
                last[i]  <= cyc;
                if (cyc - last[i] < min_gap) min_gap <= cyc - last[i];
                if (dir[i] !== dir_q[i]) dir_moved <= 1'b1;
            end
        end
    end
endmodule // stepper_drive_model

// ### tb/three_axis_stepper_pulse_controller_test.sv
// self-checking bench of the step pulse controller
`timescale 1ns/1ps
module three_axis_stepper_pulse_controller_test;
    import stepper_pkg::*;
    logic clk_sys, rst_b, bus_wr, bus_rd, cpu_wr, cpu_rd, irq, cpu_irq;
    logic supply_fault_in, power_fail_stop;
    logic [7:0] bus_addr, cpu_addr;
    logic [31:0] bus_wdata, cpu_wdata, bus_rdata, cpu_rdata, r;
    logic [2:0] home_cmd, probe_cmd, home_switch_in, probe_in, st, dr, bo;
    logic [2:0][15:0] steps;
    logic dir_moved;
    int min_gap, errors, n_checks;
    stepper_ctrl #(.WDOG_TIMEOUT(16'h07D0), .HAS_COPROC(1'b0)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .cpu_irq(cpu_irq), .home_switch_in(home_switch_in),
        .probe_in(probe_in), .supply_fault_in(supply_fault_in),
        .power_fail_stop(power_fail_stop), .step_pulse_out_1(st[0]),
        .step_pulse_out_2(st[1]), .step_pulse_out_3(st[2]), .rotation_sense_out_1(dr[0]),
        .rotation_sense_out_2(dr[1]), .rotation_sense_out_3(dr[2]),
        .current_boost_out_1(bo[0]), .current_boost_out_2(bo[1]), .current_boost_out_3(bo[2]));
    stepper_drive_model drives (.clk_sys(clk_sys), .step(st), .dir(dr), .home_cmd(home_cmd),
        .probe_cmd(probe_cmd), .home_switch_in(home_switch_in), .probe_in(probe_in),
        .steps(steps), .min_gap(min_gap), .dir_moved(dir_moved));
    // one-cycle access on the host port or the processor port
    task automatic acc(input logic cpu, input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        if (cpu) begin
            cpu_addr  <= a;
            cpu_wdata <= d;
            cpu_wr    <= wr;
            cpu_rd    <= !wr;
        end else begin
            bus_addr  <= a;
            bus_wdata <= d;
            bus_wr    <= wr;
            bus_rd    <= !wr;
        end
        @(posedge clk_sys);
        {cpu_wr, cpu_rd, bus_wr, bus_rd} <= 4'h0;
        #1 r = cpu ? cpu_rdata : bus_rdata;
    endtask
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // cut a hang short
    initial begin
        wt(20000);
        errors++;
        print_verdict();
    end
    initial begin
        {rst_b, bus_wr, bus_rd, cpu_wr, cpu_rd, supply_fault_in, power_fail_stop} = '0;
        {bus_addr, cpu_addr, bus_wdata, cpu_wdata, home_cmd, probe_cmd} = '0;
        {errors, n_checks} = '0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        acc(0, 0, A_BOARD_ID, 0);
        chk(r, {24'h0, BOARD_CODE});
        acc(0, 0, 8'h7C, 0);
        chk(r, 32'h0);
        acc(0, 1, A_MASK, 32'h22);
        acc(0, 1, A_HOST_MBOX, 32'hA5A50F0F);
        wt(1);
        chk(cpu_irq, 1);
        acc(1, 0, A_HOST_MBOX, 0);
        chk(r, 32'hA5A50F0F);
        wt(2);
        chk(cpu_irq, 0);
        acc(1, 1, A_CPU_MBOX, 32'h12345678);
        wt(2);
        chk(irq, 1);
        acc(0, 0, A_CPU_MBOX, 0);
        chk(r, 32'h12345678);
        wt(2);
        chk(irq, 0);
        home_cmd  <= 3'h5;
        probe_cmd <= 3'h2;
        wt(4);
        acc(0, 0, A_INPUTS, 0);
        chk(r[7:0], 8'h15);
        acc(1, 0, A_STATUS, 0);
        chk(r[31], 1'b0);
        // kick watchdog, boost on, then a short move on channel one
        acc(1, 1, A_CTRL, 32'h0F);
        acc(1, 1, 8'h20, 32'h80000003);
        wt(1);
        chk(bo, 3'h1);
        wt(700);
        chk(steps[0], 16'h3);
        chk(min_gap >= STEP_MIN_CYC, 1);
        chk(dir_moved, 0);
        chk(dr[0], 1);
        acc(1, 1, A_CTRL, 32'h0F);
        acc(1, 1, 8'h38, 32'hFFFFFFFE);
        acc(1, 1, 8'h3C, 32'h2);
        acc(1, 1, 8'h30, 32'h80000005);
        wt(4);
        acc(0, 0, A_STATUS, 0);
        chk(r[5], 1);
        chk(irq, 1);
        wt(300);
        chk(steps[1], 16'h0);
        acc(0, 1, A_STATUS, 32'h20);
        acc(0, 0, A_STATUS, 0);
        chk(r[5], 0);
        chk(irq, 0);
        power_fail_stop <= 1'b1;
        acc(1, 1, A_CTRL, 32'h0F);
        wt(4);
        acc(1, 1, 8'h40, 32'h3);
        wt(400);
        chk(steps[2], 16'h0);
        acc(0, 0, A_STATUS, 0);
        chk(r[4], 1);
        supply_fault_in <= 1'b1;
        wt(4);
        acc(0, 0, A_STATUS, 0);
        chk(r[3], 1);
        wt(2100);
        acc(0, 0, A_STATUS, 0);
        chk(r[2], 1);
        print_verdict();
    end
endmodule // three_axis_stepper_pulse_controller_test
